// File: host_bus_model.sv
module host_bus_model (
  input  wire logic                 clk_sys,
  input  wire uart_irq_pkg::byte_t  bus_rdata,
  output logic [2:0]                bus_addr,
  output uart_irq_pkg::byte_t       bus_wdata,
  output logic                      bus_wr,
  output logic                      bus_rd
);
  timeunit 1ns;
  timeprecision 100ps;
  import uart_irq_pkg::*;
  initial begin
    bus_addr = 3'h0;
    bus_wdata = 8'h00;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
  end
  // released lines show the inverse so stale values never look valid
  task automatic wr(input logic [2:0] a, input byte_t d);
    @(negedge clk_sys);
    {bus_addr, bus_wdata, bus_wr} = {a, d, 1'b1};
    @(negedge clk_sys);
    {bus_addr, bus_wdata, bus_wr} = {~a, ~d, 1'b0};
  endtask : wr
  task automatic rd(input logic [2:0] a, output byte_t d);
    @(negedge clk_sys);
    {bus_addr, bus_rd} = {a, 1'b1};
    @(negedge clk_sys);
    d = bus_rdata;
    {bus_addr, bus_rd} = {~a, 1'b0};
  endtask : rd
endmodule : host_bus_model

// File: rx_timeout_timer.sv
`include "uart_irq_cfg.svh"
module rx_timeout_timer #(
  parameter int CW = 16
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  input  wire logic          bit_tick,
  input  wire logic [3:0]    char_bits,
  input  wire logic          restart,
  input  wire logic          armed,
  output logic               expired
);
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] limit;
  // bits per character includes start, parity and stop framing from the caller
  assign limit = CW'(`TO_CHARS) * CW'(char_bits) + CW'(`TO_EXTRA_BITS);
  always_ff @(posedge clk_sys) begin
    if (!rst_b || restart || !armed) begin
      cnt_q   <= '0;
      expired <= 1'b0;
    end else if (bit_tick && !expired) begin
      cnt_q <= cnt_q + CW'(1);
      if (cnt_q + CW'(1) >= limit) begin
        expired <= 1'b1;
      end
    end
  end
endmodule : rx_timeout_timer

// File: uart_interrupt_fifo_control.sv
`include "uart_irq_cfg.svh"
// Functional notes
// - rx ready on char or trigger level
// - tx ready on empty, also at enable
// - line irq: overrun now, others at read
// - upper enables need enhanced-function bit
// - irq on rising rts or cts
// - report highest pending, hold until serviced
// - time-out after four chars twelve bits
// - flow irqs only with auto flow control
// - line status read clears line irq
// - rx ready below trigger, timeout on read
// - tx ready clears on status read/write
// - modem status read clears modem, flow
// - xoff/special clear on read or character
// - status code per priority level
// - bit zero low while pending
// - status bits 5..4 need enhanced bit
// - top bits show fifo enable
// - enable bit must accompany other bits
// - fifo reset bits self-clear
// - dma select switches rx ready pin only
// - trigger select gives 1/4/8/14
// - all enables and controls reset zero, rx trigger to level 1
// - enhanced bit gates upper field writes
module uart_interrupt_fifo_control #(
  parameter int FIFO_DEPTH = 16,
  parameter int TO_CW      = 16
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_b,
  input  wire logic [2:0]            bus_addr,
  input  wire uart_irq_pkg::byte_t   bus_wdata,
  input  wire logic                  bus_wr,
  input  wire logic                  bus_rd,
  output uart_irq_pkg::byte_t        bus_rdata,
  input  wire logic                  enhanced_en,
  input  wire logic                  auto_cts_en,
  input  wire logic                  auto_rts_en,
  input  wire uart_irq_pkg::level_t  rx_level,
  input  wire logic                  rx_char_in,
  input  wire logic                  rx_overrun,
  input  wire logic                  rx_head_error,
  input  wire logic                  tx_empty,
  input  wire logic                  modem_delta,
  input  wire logic                  xoff_rx,
  input  wire logic                  xon_rx,
  input  wire logic                  special_rx,
  input  wire logic                  rts_level,
  input  wire logic                  cts_pin_b,
  input  wire logic                  bit_tick,
  input  wire logic [3:0]            char_bits,
  output logic                       irq,
  output uart_irq_pkg::byte_t        interrupt_enable_q,
  output logic                       fifo_en_q,
  output logic                       rx_fifo_reset_q,
  output logic                       tx_fifo_reset_q,
  output logic                       dma_mode_q,
  output uart_irq_pkg::level_t       rx_trigger_q,
  output logic                       receive_ready_pin_b,
  output logic                       transmit_ready_pin_b
);
  import uart_irq_pkg::*;

  logic       line_q, tx_q, modem_q, xoff_q, special_q, flow_q;
  logic       tx_empty_q, rts_prev_q;
  logic       cts_s1_q, cts_s2_q, cts_prev_q;
  irq_src_t   held_q;
  logic       rx_nonempty, rx_at_trig, timeout;

  wire wr_ier   = bus_wr && (bus_addr == `ADDR_IER);
  wire wr_fcr   = bus_wr && (bus_addr == `ADDR_ISR_FCR);
  wire wr_thr   = bus_wr && (bus_addr == `ADDR_RXTX);
  wire rd_rhr   = bus_rd && (bus_addr == `ADDR_RXTX);
  wire rd_isr   = bus_rd && (bus_addr == `ADDR_ISR_FCR);
  wire rd_lsr   = bus_rd && (bus_addr == `ADDR_LSR);
  wire rd_msr   = bus_rd && (bus_addr == `ADDR_MSR);
  wire [7:0] ie = interrupt_enable_q;

  wire en_xoff  = ie[`IE_XOFF] && enhanced_en;
  wire en_rts   = ie[`IE_RTS] && enhanced_en;
  wire en_cts   = ie[`IE_CTS] && enhanced_en;

  wire [7:0] ier_d = enhanced_en ? bus_wdata : {ie[7:4], bus_wdata[3:0]};

  wire level_t trig_d = (bus_wdata[7:6] == 2'b00) ? `TRIG_0 :
                        (bus_wdata[7:6] == 2'b01) ? `TRIG_1 :
                        (bus_wdata[7:6] == 2'b10) ? `TRIG_2 : `TRIG_3;

  assign rx_nonempty = (rx_level != 5'h00);
  assign rx_at_trig  = fifo_en_q ? (rx_level >= rx_trigger_q) : rx_nonempty;

  rx_timeout_timer #(.CW(TO_CW)) u_timeout (
    .clk_sys   (clk_sys),
    .rst_b     (rst_b),
    .bit_tick  (bit_tick),
    .char_bits (char_bits),
    .restart   (rx_char_in || rd_rhr),
    .armed     (fifo_en_q && rx_nonempty),
    .expired   (timeout)
  );

  wire tx_rise   = tx_empty && !tx_empty_q;
  wire tx_en_set = wr_ier && ier_d[`IE_TX_READY] && !ie[`IE_TX_READY] && tx_empty;
  wire rts_rise  = rts_level && !rts_prev_q;
  wire cts_rise  = cts_s2_q && !cts_prev_q;
  wire flow_ev   = (rts_rise && en_rts && auto_rts_en) ||
                   (cts_rise && en_cts && auto_cts_en);
  wire line_ev   = rx_overrun || rx_head_error;

  wire p_line  = line_q && ie[`IE_LINE];
  wire p_to    = timeout && ie[`IE_RX_READY];
  wire p_rx    = rx_at_trig && ie[`IE_RX_READY];
  wire p_tx    = tx_q && ie[`IE_TX_READY];
  wire p_modem = modem_q && ie[`IE_MODEM];
  wire p_xoff  = (xoff_q || special_q) && en_xoff && enhanced_en;
  wire p_flow  = flow_q && (en_rts || en_cts);

  wire irq_src_t top = p_line  ? SRC_LINE     :
                       p_to    ? SRC_TIMEOUT  :
                       p_rx    ? SRC_RX_READY :
                       p_tx    ? SRC_TX_READY :
                       p_modem ? SRC_MODEM    :
                       p_xoff  ? SRC_XOFF     :
                       p_flow  ? SRC_FLOW     : SRC_NONE;

  // held source stays presented while still pending
  wire held_live = (held_q == SRC_LINE     && p_line)  ||
                   (held_q == SRC_TIMEOUT  && p_to)    ||
                   (held_q == SRC_RX_READY && p_rx)    ||
                   (held_q == SRC_TX_READY && p_tx)    ||
                   (held_q == SRC_MODEM    && p_modem) ||
                   (held_q == SRC_XOFF     && p_xoff)  ||
                   (held_q == SRC_FLOW     && p_flow);
  wire irq_src_t shown = held_live ? held_q : top;

  logic [5:0] code;
  always_comb begin
    unique case (shown)
      SRC_LINE:     code = `CODE_LINE;
      SRC_TIMEOUT:  code = `CODE_TIMEOUT;
      SRC_RX_READY: code = `CODE_RX_READY;
      SRC_TX_READY: code = `CODE_TX_READY;
      SRC_MODEM:    code = `CODE_MODEM;
      SRC_XOFF:     code = `CODE_XOFF;
      SRC_FLOW:     code = `CODE_FLOW;
      SRC_NONE:     code = `CODE_NONE;
      default:      code = `CODE_NONE;
    endcase
  end

  wire [7:0] isr_val = {fifo_en_q, fifo_en_q, code};
  wire [7:0] rdata_d = rd_isr ? isr_val :
                       (bus_rd && bus_addr == `ADDR_IER) ? ie : 8'h00;

  wire fcr_take = wr_fcr && bus_wdata[`FC_ENABLE];

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      interrupt_enable_q <= `REG_RESET;
      fifo_en_q          <= 1'b0;
      dma_mode_q         <= 1'b0;
      rx_trigger_q       <= `TRIG_0;
      rx_fifo_reset_q    <= 1'b0;
      tx_fifo_reset_q    <= 1'b0;
    end else begin
      if (wr_ier) begin
        interrupt_enable_q <= ier_d;
      end
      if (wr_fcr) begin
        fifo_en_q <= bus_wdata[`FC_ENABLE];
      end
      if (fcr_take) begin
        dma_mode_q   <= bus_wdata[`FC_DMA];
        rx_trigger_q <= trig_d;
      end
      rx_fifo_reset_q <= fcr_take && bus_wdata[`FC_RX_RESET];
      tx_fifo_reset_q <= fcr_take && bus_wdata[`FC_TX_RESET];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      line_q     <= 1'b0;
      tx_q       <= 1'b0;
      modem_q    <= 1'b0;
      xoff_q     <= 1'b0;
      special_q  <= 1'b0;
      flow_q     <= 1'b0;
      tx_empty_q <= 1'b1;
      rts_prev_q <= 1'b0;
      cts_s1_q   <= 1'b1;
      cts_s2_q   <= 1'b1;
      cts_prev_q <= 1'b1;
      held_q     <= SRC_NONE;
    end else begin
      tx_empty_q <= tx_empty;
      rts_prev_q <= rts_level;
      cts_s1_q   <= cts_pin_b;
      cts_s2_q   <= cts_s1_q;
      cts_prev_q <= cts_s2_q;
      line_q  <= line_ev || (line_q && !rd_lsr);
      // tx clear on isr read while tx ready is shown, or thr write
      tx_q    <= tx_rise || tx_en_set || (tx_q && !(rd_isr && shown == SRC_TX_READY) && !wr_thr);
      modem_q <= modem_delta || (modem_q && !rd_msr);
      flow_q  <= flow_ev || (flow_q && !rd_msr);
      xoff_q    <= xoff_rx || (xoff_q && !rd_isr && !xon_rx);
      special_q <= special_rx || (special_q && !rd_isr && !rx_char_in);
      held_q  <= shown;
    end
  end

  // outputs registered
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      bus_rdata            <= 8'h00;
      irq                  <= 1'b0;
      receive_ready_pin_b  <= 1'b1;
      transmit_ready_pin_b <= 1'b0;
    end else begin
      bus_rdata <= rdata_d;
      // pending when code bit zero low
      irq <= !code[0];
      receive_ready_pin_b  <= dma_mode_q ? !(rx_at_trig || timeout) : !rx_nonempty;
      transmit_ready_pin_b <= dma_mode_q ? !tx_empty : !tx_empty;
    end
  end
endmodule : uart_interrupt_fifo_control

// File: uart_interrupt_fifo_control_sva.sv
`include "uart_irq_cfg.svh"
module uart_interrupt_fifo_control_sva (
  input wire logic                  clk_sys,
  input wire logic                  rst_b,
  input wire logic [2:0]            bus_addr,
  input wire uart_irq_pkg::byte_t   bus_wdata,
  input wire logic                  bus_wr,
  input wire logic                  bus_rd,
  input wire uart_irq_pkg::byte_t   bus_rdata,
  input wire logic                  enhanced_en,
  input wire logic                  irq,
  input wire uart_irq_pkg::byte_t   interrupt_enable_q,
  input wire logic                  fifo_en_q,
  input wire logic                  rx_fifo_reset_q,
  input wire logic                  dma_mode_q,
  input wire uart_irq_pkg::level_t  rx_trigger_q
);
  import uart_irq_pkg::*;
  localparam level_t TRIG_TAB [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
  wire logic fcr_wr = bus_wr && bus_addr == `ADDR_ISR_FCR;
  wire logic isr_rd = bus_rd && bus_addr == `ADDR_ISR_FCR;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_reset_defaults:
    assert property ($rose(rst_b) |-> interrupt_enable_q == 8'h00 && !fifo_en_q && !irq)
      else $error("registers not at reset defaults");
  a_fifo_reset_pulse:
    assert property (fcr_wr && bus_wdata[1:0] == 2'b11 |=> rx_fifo_reset_q ##1 !rx_fifo_reset_q)
      else $error("rx fifo reset not a single pulse");
  a_enable_gate:
    assert property (fcr_wr && !bus_wdata[0] |=> !fifo_en_q && $stable(rx_trigger_q))
      else $error("fifo control taken without enable bit");
  a_trigger_select:
    assert property (fcr_wr && bus_wdata[0] |=> rx_trigger_q == TRIG_TAB[$past(bus_wdata[7:6])])
      else $error("wrong receive trigger level");
  a_dma_select:
    assert property (fcr_wr && bus_wdata[0] |=> fifo_en_q && dma_mode_q == $past(bus_wdata[3]))
      else $error("dma mode not taken");
  a_upper_gate:
    assert property (bus_wr && bus_addr == `ADDR_IER && !enhanced_en |=>
      interrupt_enable_q == {$past(interrupt_enable_q[7:4]), $past(bus_wdata[3:0])})
      else $error("enable write not gated");
  a_fifo_status:
    assert property (isr_rd |=> bus_rdata[7:6] == {2{$past(fifo_en_q)}})
      else $error("status top bits wrong");
  a_pending_bit:
    assert property (isr_rd |=> bus_rdata[0] == !irq)
      else $error("status bit zero disagrees with irq");
  a_disabled_quiet:
    assert property (interrupt_enable_q == 8'h00 |=> !irq)
      else $error("irq with all sources disabled");
  c_fifo_on: cover property (fcr_wr && bus_wdata[0]);
  c_irq_rise: cover property ($rose(irq));
  c_isr_pending: cover property (isr_rd && irq);
endmodule : uart_interrupt_fifo_control_sva

bind uart_interrupt_fifo_control uart_interrupt_fifo_control_sva i_uart_interrupt_fifo_control_sva (
  .clk_sys, .rst_b, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .enhanced_en, .irq,
  .interrupt_enable_q, .fifo_en_q, .rx_fifo_reset_q, .dma_mode_q, .rx_trigger_q);

// File: uart_interrupt_fifo_control_tb.sv
`include "uart_irq_cfg.svh"
module uart_interrupt_fifo_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import uart_irq_pkg::*;
  logic clk_sys = 1'b0, rst_b, bus_wr, bus_rd, enhanced_en, auto_cts_en, auto_rts_en, irq;
  logic rx_char_in, rx_overrun, rx_head_error, tx_empty, modem_delta, xoff_rx, xon_rx;
  logic special_rx, rts_level, cts_pin_b, bit_tick, fifo_en_q, dma_mode_q;
  logic [2:0] bus_addr;
  logic [3:0] char_bits;
  byte_t      bus_wdata, bus_rdata, interrupt_enable_q;
  byte_t      scratch;
  level_t     rx_level, rx_trigger_q;
  int         bad_count, check_count;
  level_t     trig_tab [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};
  always #2.5 clk_sys = ~clk_sys;
  host_bus_model i_host_bus_model (.clk_sys, .bus_rdata, .bus_addr, .bus_wdata, .bus_wr, .bus_rd);
  uart_interrupt_fifo_control i_uart_interrupt_fifo_control (
    .clk_sys, .rst_b, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .enhanced_en,
    .auto_cts_en, .auto_rts_en, .rx_level, .rx_char_in, .rx_overrun, .rx_head_error, .tx_empty,
    .modem_delta, .xoff_rx, .xon_rx, .special_rx, .rts_level, .cts_pin_b, .bit_tick, .char_bits,
    .irq, .interrupt_enable_q, .fifo_en_q, .rx_fifo_reset_q(), .tx_fifo_reset_q(), .dma_mode_q,
    .rx_trigger_q, .receive_ready_pin_b(), .transmit_ready_pin_b());
  task automatic chk(string what, byte_t seen, byte_t exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(logic [2:0] a, byte_t d);
    i_host_bus_model.wr(a, d);
  endtask : wr
  task automatic rdchk(logic [2:0] a, byte_t exp, string what);
    byte_t v;
    i_host_bus_model.rd(a, v);
    chk(what, v, exp);
  endtask : rdchk
  task automatic interrupt_status(byte_t exp);
    rdchk(`ADDR_ISR_FCR, exp, "interrupt_status");
  endtask : interrupt_status
  task automatic pulse(ref logic s);
    @(negedge clk_sys) s = 1'b1;
    @(negedge clk_sys) s = 1'b0;
  endtask : pulse
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    {rst_b, enhanced_en, auto_cts_en, auto_rts_en, rx_char_in, rx_overrun} = 6'h00;
    {rx_head_error, tx_empty, modem_delta, xoff_rx, xon_rx, special_rx} = 6'h00;
    {rts_level, cts_pin_b, bit_tick, rx_level, char_bits} = {3'h0, 5'h00, 4'h1};
    repeat (5) @(negedge clk_sys);
    rst_b = 1'b1;
    rdchk(`ADDR_IER, 8'h00, "interrupt_enable");
    interrupt_status(8'h01);
    for (int t = 0; t < 4; t++) begin
      wr(`ADDR_ISR_FCR, {t[1:0], 6'h09});
      chk("rx_trigger", {3'h0, rx_trigger_q}, {3'h0, trig_tab[t]});
      chk("dma_mode", {7'h0, dma_mode_q}, 8'h01);
    end
    wr(`ADDR_ISR_FCR, 8'h00);
    chk("rx_trigger", {3'h0, rx_trigger_q}, 8'h0e);
    interrupt_status(8'h01);
    // host always sets the enable bit together with other control bits
    wr(`ADDR_ISR_FCR, 8'h43);
    wr(`ADDR_IER, 8'hff);
    rdchk(`ADDR_IER, 8'h0f, "interrupt_enable");
    pulse(rx_overrun);
    rx_level = 5'h04;
    pulse(rx_char_in);
    pulse(modem_delta);
    interrupt_status(8'hc6);
    rdchk(`ADDR_LSR, 8'h00, "line_status_seen");
    interrupt_status(8'hc4);
    rx_level = 5'h03;
    interrupt_status(8'hc0);
    i_host_bus_model.wr(`ADDR_ISR_FCR, 8'h43);
    i_host_bus_model.rd(`ADDR_MSR, scratch);
    interrupt_status(8'hc1);
    tx_empty = 1'b1;
    interrupt_status(8'hc2);
    interrupt_status(8'hc1);
    wr(`ADDR_IER, 8'h00);
    wr(`ADDR_IER, 8'h02);
    interrupt_status(8'hc2);
    wr(`ADDR_IER, 8'h00);
    wr(`ADDR_IER, 8'h02);
    wr(`ADDR_RXTX, 8'h5a);
    interrupt_status(8'hc1);
    wr(`ADDR_IER, 8'h00);
    pulse(modem_delta);
    interrupt_status(8'hc1);
    {tx_empty, enhanced_en} = 2'b01;
    wr(`ADDR_IER, 8'ha0);
    rdchk(`ADDR_IER, 8'ha0, "interrupt_enable");
    cts_pin_b = 1'b1;
    interrupt_status(8'hc1);
    {cts_pin_b, auto_cts_en} = 2'b01;
    repeat (4) @(negedge clk_sys);
    cts_pin_b = 1'b1;
    repeat (4) @(negedge clk_sys);
    interrupt_status(8'he0);
    i_host_bus_model.rd(`ADDR_MSR, scratch);
    interrupt_status(8'hc1);
    pulse(xoff_rx);
    interrupt_status(8'hd0);
    pulse(xoff_rx);
    pulse(xon_rx);
    interrupt_status(8'hc1);
    wr(`ADDR_IER, 8'h01);
    rx_level = 5'h01;
    pulse(rx_char_in);
    bit_tick = 1'b1;
    interrupt_status(8'hc1);
    repeat (20) @(negedge clk_sys);
    interrupt_status(8'hcc);
    i_host_bus_model.rd(`ADDR_RXTX, scratch);
    interrupt_status(8'hc1);
    wrap_up();
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    bad_count++;
    wrap_up();
  end
endmodule : uart_interrupt_fifo_control_tb

// File: uart_irq_cfg.svh
`ifndef UART_IRQ_CFG_SVH
`define UART_IRQ_CFG_SVH
// register addresses on the 3-bit channel bus
`define ADDR_RXTX       3'h0
`define ADDR_IER        3'h1
`define ADDR_ISR_FCR    3'h2
`define ADDR_LSR        3'h5
`define ADDR_MSR        3'h6
// interrupt_enable fields
`define IE_RX_READY     0
`define IE_TX_READY     1
`define IE_LINE         2
`define IE_MODEM        3
`define IE_SLEEP        4
`define IE_XOFF         5
`define IE_RTS          6
`define IE_CTS          7
// fifo_control fields
`define FC_ENABLE       0
`define FC_RX_RESET     1
`define FC_TX_RESET     2
`define FC_DMA          3
`define FC_TRIG_LO      6
// status codes, bits 5..0
`define CODE_LINE       6'h06
`define CODE_TIMEOUT    6'h0c
`define CODE_RX_READY   6'h04
`define CODE_TX_READY   6'h02
`define CODE_MODEM      6'h00
`define CODE_XOFF       6'h10
`define CODE_FLOW       6'h20
`define CODE_NONE       6'h01
// receive trigger levels
`define TRIG_0          5'h01
`define TRIG_1          5'h04
`define TRIG_2          5'h08
`define TRIG_3          5'h0e
// receive time-out: four characters plus twelve bits
`define TO_CHARS        4
`define TO_EXTRA_BITS   12
`define REG_RESET       8'h00
`endif

// File: uart_irq_pkg.sv
package uart_irq_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [4:0] level_t;
  typedef enum logic [3:0] {
    SRC_NONE, SRC_LINE, SRC_TIMEOUT, SRC_RX_READY,
    SRC_TX_READY, SRC_MODEM, SRC_XOFF, SRC_FLOW
  } irq_src_t;
endpackage : uart_irq_pkg
